// ### rtl/blfs_pkg.sv
// Purpose: shared constants of the ballast lamp fault supervisor
// Assumes: 25 MHz system clock
// Notes: times are held in their printed unit, cycle counts derive from them
`default_nettype none
package blfs_pkg;
  localparam int CLK_NS = 40;
  localparam int CLK_MHZ = 25;
  // fault filters and retry delay
  localparam int T_FILTER_NS = 620000;
  localparam int FILTER_CYC = T_FILTER_NS / CLK_NS;
  localparam int T_RETRY_US = 200000;
  localparam int RETRY_CYC = T_RETRY_US * CLK_MHZ;
  localparam int T_DC_FILTER_US = 2500000;
  localparam int DC_FILTER_CYC = T_DC_FILTER_US * CLK_MHZ;
  // preheat quantisation: full range split into equal steps
  localparam int PH_STEPS = 127;
  localparam int T_PH_MAX_US = 2500000;
  localparam int PH_STEP_CYC = (T_PH_MAX_US * CLK_MHZ) / PH_STEPS;
  // dead time: least rounds up, longest rounds down
  localparam int T_DT_MIN_NS = 1250;
  localparam int T_DT_MAX_NS = 2500;
  localparam logic [6:0] DT_MIN_CYC = 7'((T_DT_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [6:0] DT_MAX_CYC = 7'(T_DT_MAX_NS / CLK_NS);
  // wishbone register map, byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_PREHEAT = 8'h08;
  localparam logic [7:0] ADR_FAULT = 8'h0C;
  localparam int CTRL_RUN_EN_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [6:0] PREHEAT_RESET = 7'h00;
  // source current selection codes
  typedef enum logic [2:0] {
    BLFS_SRC_OFF = 3'h0,
    BLFS_SRC_NORMAL = 3'h1,
    BLFS_SRC_REDUCED = 3'h2,
    BLFS_SRC_HS_OPEN_HIGH = 3'h3,
    BLFS_SRC_HS_OPEN_LOW = 3'h4
  } blfs_src_t;
  typedef enum logic [3:0] {
    BLFS_ST_DETECT = 4'h1,
    BLFS_ST_RUN = 4'h2,
    BLFS_ST_PDOWN = 4'h4,
    BLFS_ST_LATCH = 4'h8
  } blfs_state_t;
endpackage : blfs_pkg
`default_nettype wire

// ### rtl/blfs_sync.sv
// Purpose: two-flop synchroniser for comparator levels
// Assumes: inputs are quasi-static levels
// Notes: first stage is read by the second stage only
`default_nettype none
module blfs_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o <= '0;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : blfs_sync
`default_nettype wire

// ### rtl/blfs_filter.sv
// Purpose: continuous-condition fault filter
// Assumes: limit is at least one
// Notes: trip stays high while the condition holds past the limit
`default_nettype none
module blfs_filter #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic clr_i,
  input wire logic cond_i,
  input wire logic [W-1:0] limit_i,
  output logic trip_o
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (en_i) begin
      // any dropout restarts the window
      if (clr_i || !cond_i) begin
        cnt_reg <= '0;
      end else if (cnt_reg != limit_i) begin
        cnt_reg <= cnt_reg + W'(1);
      end
    end
  end

  assign trip_o = cond_i && !clr_i && (cnt_reg == limit_i);
endmodule : blfs_filter
`default_nettype wire

// ### rtl/blfs_top.sv
// Purpose: lamp fault supervision, filament detection, retry sequence and gate gating
// Assumes: comparator levels asynchronous, gate and pfc requests from on-chip clocked logic
// Notes: registers over classic wishbone, one-cycle ack
`default_nettype none
module blfs_top
  import blfs_pkg::*;
#(
  parameter int FILTER_CYCLES = blfs_pkg::FILTER_CYC,
  parameter int RETRY_CYCLES = blfs_pkg::RETRY_CYC,
  parameter int DC_FILTER_CYCLES = blfs_pkg::DC_FILTER_CYC,
  parameter int PH_STEP_CYCLES = blfs_pkg::PH_STEP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic vcc_ok_i,
  input wire logic vcc_start_i,
  input wire logic res_upper_i,
  input wire logic res_lower_i,
  input wire logic res_high_i,
  input wire logic res_grounded_i,
  input wire logic [1:0] lamp_sink_current_i,
  input wire logic [1:0] lamp_grounded_i,
  input wire logic [1:0] lamp_ac_over_i,
  input wire logic [1:0] lamp_dc_over_i,
  input wire logic [1:0] lamp_channel_enable_level_i,
  input wire logic high_side_supply_rise_i,
  input wire logic high_side_supply_hold_i,
  input wire logic node_settled_i,
  input wire logic low_gate_req_i,
  input wire logic high_gate_req_i,
  input wire logic discontinuous_conduction_i,
  input wire logic pfc_off_time_i,
  output blfs_pkg::blfs_src_t src_sel_o,
  output logic filament_threshold_lower_o,
  output logic low_gate_drive_o,
  output logic high_gate_drive_o,
  output logic aux_drive_o,
  output logic power_down_o,
  output logic start_permit_o,
  output logic preheat_active_o
);
  import blfs_pkg::*;

  localparam int NSYNC = 19;
  logic [NSYNC-1:0] sync_q;
  logic vcc_ok_s, vcc_start_s, res_upper_s, res_lower_s, res_high_s, res_gnd_s;
  logic [1:0] sink_s, lamp_gnd_s, ac_s, dc_s, lamp_en_s;
  logic hs_rise_s, hs_hold_s, settled_s;

  blfs_sync #(.W(NSYNC)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({vcc_ok_i, vcc_start_i, res_upper_i, res_lower_i, res_high_i, res_grounded_i,
          lamp_sink_current_i, lamp_grounded_i, lamp_ac_over_i, lamp_dc_over_i,
          lamp_channel_enable_level_i, high_side_supply_rise_i, high_side_supply_hold_i,
          node_settled_i}),
    .q_o(sync_q)
  );
  assign {vcc_ok_s, vcc_start_s, res_upper_s, res_lower_s, res_high_s, res_gnd_s, sink_s,
          lamp_gnd_s, ac_s, dc_s, lamp_en_s, hs_rise_s, hs_hold_s, settled_s} = sync_q;

  blfs_state_t state_reg;
  logic attempt_reg;
  logic lo_open_reg, hi_open_reg;
  logic [1:0] ch_en_reg;
  logic run_en_reg;
  logic [6:0] ph_steps_reg;
  logic res_fault_reg;
  logic [1:0] ac_fault_reg, dc_fault_reg;
  logic [31:0] retry_cnt_reg;
  logic [6:0] ph_left_reg;
  logic [31:0] ph_cnt_reg;
  logic hs_en_reg;
  logic [6:0] dt_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  logic res_en, in_run, filament_ok, fault, removal, dt_done;
  logic res_trip;
  logic [1:0] ac_trip, dc_trip;

  assign res_en = !res_gnd_s;
  assign in_run = (state_reg == BLFS_ST_RUN);
  assign filament_ok = !lo_open_reg && !hi_open_reg;
  assign start_permit_o = (state_reg == BLFS_ST_DETECT) && vcc_ok_s && vcc_start_s &&
                          filament_ok && run_en_reg;
  // lamp taken out: restart filament opens or an active lamp channel loses its current
  assign removal = (res_en && res_upper_s) || (|(ch_en_reg & ~sink_s));

  blfs_filter #(.W(32)) u_res_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(clk_en_i),
    .clr_i(!in_run || !res_en),
    .cond_i(res_high_s),
    .limit_i(32'(FILTER_CYCLES)),
    .trip_o(res_trip)
  );

  for (genvar i = 0; i < 2; i++) begin : g_lamp
    blfs_filter #(.W(32)) u_ac_filt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(clk_en_i),
      .clr_i(!in_run || !ch_en_reg[i]),
      .cond_i(ac_s[i]),
      .limit_i(32'(FILTER_CYCLES)),
      .trip_o(ac_trip[i])
    );
    blfs_filter #(.W(32)) u_dc_filt (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(clk_en_i),
      .clr_i(!in_run || !ch_en_reg[i]),
      .cond_i(dc_s[i]),
      .limit_i(32'(DC_FILTER_CYCLES)),
      .trip_o(dc_trip[i])
    );
  end

  assign fault = res_trip || (|ac_trip) || (|dc_trip);

  // supervisor sequence
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= BLFS_ST_DETECT;
      attempt_reg <= 1'b0;
      retry_cnt_reg <= '0;
    end else if (clk_en_i) begin
      if (!vcc_ok_s) begin
        state_reg <= BLFS_ST_DETECT;
        attempt_reg <= 1'b0;
        retry_cnt_reg <= '0;
      end else begin
        unique case (state_reg)
          BLFS_ST_DETECT: begin
            if (start_permit_o) begin
              state_reg <= BLFS_ST_RUN;
            end
          end
          BLFS_ST_RUN: begin
            if (fault) begin
              state_reg <= attempt_reg ? BLFS_ST_LATCH : BLFS_ST_PDOWN;
              attempt_reg <= 1'b1;
              retry_cnt_reg <= '0;
            end
          end
          BLFS_ST_PDOWN: begin
            if (retry_cnt_reg == 32'(RETRY_CYCLES - 1)) begin
              state_reg <= BLFS_ST_DETECT;
            end else begin
              retry_cnt_reg <= retry_cnt_reg + 32'h1;
            end
          end
          BLFS_ST_LATCH: begin
            if (removal) begin
              state_reg <= BLFS_ST_DETECT;
              attempt_reg <= 1'b0;
            end
          end
          default: state_reg <= BLFS_ST_DETECT;
        endcase
      end
    end
  end

  // filament detection before start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_open_reg <= 1'b0;
      hi_open_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!vcc_ok_s || !res_en) begin
        lo_open_reg <= 1'b0;
      end else if (!lo_open_reg && res_upper_s && state_reg == BLFS_ST_DETECT) begin
        lo_open_reg <= 1'b1;
      end else if (lo_open_reg && !res_lower_s) begin
        lo_open_reg <= 1'b0;
      end
      if (!vcc_ok_s) begin
        hi_open_reg <= 1'b0;
      end else if (state_reg == BLFS_ST_DETECT && !vcc_start_s) begin
        hi_open_reg <= (|ch_en_reg) && !(|(ch_en_reg & sink_s));
      end
    end
  end

  // lamp channel enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch_en_reg <= 2'h3;
    end else if (clk_en_i) begin
      for (int i = 0; i < 2; i++) begin
        if (in_run && !ch_en_reg[i] && lamp_en_s[i]) begin
          ch_en_reg[i] <= 1'b1;
        end else if (lamp_gnd_s[i] && !in_run) begin
          ch_en_reg[i] <= 1'b0;
        end else if (!vcc_ok_s) begin
          ch_en_reg[i] <= 1'b1;
        end
      end
    end
  end

  // sticky fault causes; a new trip wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      res_fault_reg <= 1'b0;
      ac_fault_reg <= '0;
      dc_fault_reg <= '0;
    end else if (clk_en_i) begin
      if (!vcc_ok_s || (state_reg == BLFS_ST_LATCH && removal)) begin
        res_fault_reg <= 1'b0;
        ac_fault_reg <= '0;
        dc_fault_reg <= '0;
      end
      if (res_trip) begin
        res_fault_reg <= 1'b1;
      end
      if (|ac_trip) begin
        ac_fault_reg <= ac_fault_reg | ac_trip;
      end
      if (|dc_trip) begin
        dc_fault_reg <= dc_fault_reg | dc_trip;
      end
    end
  end

  // preheat timer, loaded on entry to run
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_left_reg <= '0;
      ph_cnt_reg <= '0;
    end else if (clk_en_i) begin
      if (start_permit_o) begin
        ph_left_reg <= ph_steps_reg;
        ph_cnt_reg <= '0;
      end else if (!in_run) begin
        ph_left_reg <= '0;
      end else if (ph_left_reg != 7'h00) begin
        if (ph_cnt_reg == 32'(PH_STEP_CYCLES - 1)) begin
          ph_cnt_reg <= '0;
          ph_left_reg <= ph_left_reg - 7'h01;
        end else begin
          ph_cnt_reg <= ph_cnt_reg + 32'h1;
        end
      end
    end
  end
  assign preheat_active_o = in_run && (ph_left_reg != 7'h00);

  // high side supply hysteresis
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_en_reg <= 1'b0;
    end else if (clk_en_i) begin
      if (!hs_hold_s) begin
        hs_en_reg <= 1'b0;
      end else if (hs_rise_s) begin
        hs_en_reg <= 1'b1;
      end
    end
  end

  // gate drives with adaptive dead time: end early once the node settles after the minimum
  assign dt_done = (dt_cnt_reg >= DT_MAX_CYC) || (dt_cnt_reg >= DT_MIN_CYC && settled_s);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_gate_drive_o <= 1'b0;
      high_gate_drive_o <= 1'b0;
      dt_cnt_reg <= '0;
    end else if (clk_en_i) begin
      if (!vcc_ok_s || !in_run || fault) begin
        low_gate_drive_o <= 1'b0;
        high_gate_drive_o <= 1'b0;
      end else begin
        low_gate_drive_o <= low_gate_req_i && (low_gate_drive_o || (!high_gate_drive_o &&
                            !high_gate_req_i && dt_done));
        high_gate_drive_o <= high_gate_req_i && hs_en_reg && (high_gate_drive_o ||
                             (!low_gate_drive_o && dt_done));
      end
      if (low_gate_drive_o || high_gate_drive_o) begin
        dt_cnt_reg <= '0;
      end else if (dt_cnt_reg != DT_MAX_CYC) begin
        dt_cnt_reg <= dt_cnt_reg + 7'h01;
      end
    end
  end

  assign aux_drive_o = in_run && discontinuous_conduction_i && pfc_off_time_i;
  assign power_down_o = (state_reg == BLFS_ST_PDOWN) || (state_reg == BLFS_ST_LATCH);
  assign filament_threshold_lower_o = lo_open_reg;

  always_comb begin
    if (!vcc_ok_s || !res_en || power_down_o) begin
      src_sel_o = BLFS_SRC_OFF;
    end else if (lo_open_reg) begin
      src_sel_o = hi_open_reg ? BLFS_SRC_HS_OPEN_LOW : BLFS_SRC_REDUCED;
    end else begin
      src_sel_o = hi_open_reg ? BLFS_SRC_HS_OPEN_HIGH : BLFS_SRC_NORMAL;
    end
  end

  // wishbone slave: ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= '0;
      run_en_reg <= CTRL_RESET;
      ph_steps_reg <= PREHEAT_RESET;
    end else if (clk_en_i) begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
      if (wb_cyc_i && wb_stb_i && !ack_reg) begin
        if (wb_we_i && wb_sel_i[0]) begin
          if (wb_adr_i == ADR_CTRL) begin
            run_en_reg <= wb_dat_i[CTRL_RUN_EN_BIT];
          end
          if (wb_adr_i == ADR_PREHEAT) begin
            ph_steps_reg <= wb_dat_i[6:0];
          end
        end
        unique case (wb_adr_i)
          ADR_CTRL: rdata_reg <= {31'h0, run_en_reg};
          ADR_STATUS: rdata_reg <= {16'h0, 4'(state_reg), attempt_reg, lo_open_reg,
                                    hi_open_reg, ch_en_reg, res_en, hs_en_reg,
                                    preheat_active_o, 4'h0};
          ADR_PREHEAT: rdata_reg <= {25'h0, ph_steps_reg};
          ADR_FAULT: rdata_reg <= {27'h0, dc_fault_reg, ac_fault_reg, res_fault_reg};
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_lockout_high_gate: assert property (clk_en_i && !vcc_ok_s |=> !high_gate_drive_o)
    else $error("high gate active after lockout");
  a_gates_exclusive: assert property (!(low_gate_drive_o && high_gate_drive_o))
    else $error("both gates driven");
  a_dead_time_min: assert property ($rose(high_gate_drive_o) |->
    $past(dt_cnt_reg) >= DT_MIN_CYC) else $error("dead time too short");
  a_normal_source: assert property (vcc_ok_s && res_en && !power_down_o && filament_ok
    |-> src_sel_o == BLFS_SRC_NORMAL) else $error("normal current not selected");
  a_reduced_source: assert property (vcc_ok_s && res_en && !power_down_o && lo_open_reg &&
    !hi_open_reg |-> src_sel_o == BLFS_SRC_REDUCED && filament_threshold_lower_o)
    else $error("reduced current not selected");
  a_high_open_src: assert property (vcc_ok_s && res_en && !power_down_o && hi_open_reg &&
    !lo_open_reg |-> src_sel_o == BLFS_SRC_HS_OPEN_HIGH)
    else $error("raised current not selected");
  a_open_blocks_start: assert property (lo_open_reg || hi_open_reg |-> !start_permit_o)
    else $error("start with open filament");
  a_first_fault_pdown: assert property (clk_en_i && vcc_ok_s && in_run && fault &&
    !attempt_reg |=> state_reg == BLFS_ST_PDOWN && power_down_o && !low_gate_drive_o)
    else $error("first fault not powered down");
  a_second_fault_latch: assert property (clk_en_i && vcc_ok_s && in_run && fault &&
    attempt_reg |=> state_reg == BLFS_ST_LATCH) else $error("second fault not latched");
  a_aux_only_dcm: assert property (aux_drive_o |-> discontinuous_conduction_i &&
    pfc_off_time_i && in_run) else $error("aux drive outside dcm off-time");
  a_hs_supply_drop: assert property (clk_en_i && !hs_hold_s |=> !hs_en_reg &&
    !$rose(high_gate_drive_o)) else $error("high side kept on low supply");

  c_enter_run: cover property (state_reg == BLFS_ST_DETECT ##1 in_run);
  c_retry: cover property (state_reg == BLFS_ST_PDOWN ##1 state_reg == BLFS_ST_DETECT);
  c_latched: cover property (state_reg == BLFS_ST_LATCH);
  c_preheat_end: cover property ($fell(preheat_active_o) && in_run);
endmodule : blfs_top
`default_nettype wire

// ### tb/blfs_front.sv
// Purpose: far-side model of the restart sense network and half-bridge node
// Assumes: selected source current times sense resistance plus a lamp offset
// Notes: currents in 0.1 uA steps, voltages in mV
`default_nettype none
module blfs_front
  import blfs_pkg::*;
(
  input wire logic clk_i,
  input wire blfs_pkg::blfs_src_t src_sel_i,
  input wire logic low_gate_i,
  input wire logic high_gate_i,
  input wire logic [15:0] res_kohm_i,
  input wire logic [15:0] ext_mv_i,
  output logic res_upper_o,
  output logic res_lower_o,
  output logic res_high_o,
  output logic node_settled_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cur;
  int mv;
  int off_cnt = 0;
  always_comb begin
    case (src_sel_i)
      BLFS_SRC_NORMAL: cur = 213;
      BLFS_SRC_REDUCED: cur = 177;
      BLFS_SRC_HS_OPEN_HIGH: cur = 426;
      BLFS_SRC_HS_OPEN_LOW: cur = 354;
      default: cur = 0;
    endcase
    mv = cur * int'(res_kohm_i) / 10 + int'(ext_mv_i);
  end
  // comparators report raw levels, threshold choice is up to the device
  assign res_upper_o = mv > 1600;
  assign res_lower_o = mv > 1300;
  assign res_high_o = mv > 3200;
  // node swings late on purpose, so the adaptive dead time must wait for it
  always_ff @(posedge clk_i) begin
    if (low_gate_i || high_gate_i) begin
      off_cnt <= 0;
    end else if (off_cnt < 40) begin
      off_cnt <= off_cnt + 1;
    end
  end
  assign node_settled_o = off_cnt >= 40;
endmodule : blfs_front
`default_nettype wire

// ### tb/test_ballast_lamp_fault_supervisor.sv
// Purpose: self-checking bench for the lamp fault supervisor
// Assumes: shortened filter, retry, dc filter and preheat step counts
// Notes: front-end model supplies restart comparators and node settling
`default_nettype none
module test_ballast_lamp_fault_supervisor
  import blfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FILT = 8;
  localparam int RETRY = 10;
  localparam int DCF = 20;
  localparam int PHS = 4;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} blfs_row_t;
  blfs_row_t rows [9] = '{'{1'h0, ADR_CTRL, 32'h0, 32'h0}, '{1'h0, ADR_PREHEAT, 32'h0, 32'h0},
    '{1'h1, ADR_PREHEAT, 32'h2, 32'h0}, '{1'h0, ADR_PREHEAT, 32'h0, 32'h2},
    '{1'h1, 8'h10, 32'h5, 32'h0}, '{1'h0, 8'h10, 32'h0, 32'h0},
    '{1'h0, ADR_FAULT, 32'h0, 32'h0}, '{1'h1, ADR_CTRL, 32'h1, 32'h0},
    '{1'h0, ADR_CTRL, 32'h0, 32'h1}};
  logic clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, we = 1'h0, vok = 1'h0, vst = 1'h0;
  logic hsr = 1'h0, hsh = 1'h0, lreq = 1'h0, hreq = 1'h0, discontinuous_conduction = 1'h0, poff = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic [1:0] sink = 2'h0, acov = 2'h0, dcov = 2'h0, lgnd = 2'h0, len = 2'h0;
  logic rgnd = 1'h0;
  logic [15:0] kohm = 16'h0005, ext = 16'h0000;
  logic ack, thr, lgd, hgd, aux, pd, sp, pha, up, lo, hi, ns;
  blfs_src_t src;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  always #20 clk = ~clk;
  blfs_top #(.FILTER_CYCLES(FILT), .RETRY_CYCLES(RETRY), .DC_FILTER_CYCLES(DCF),
    .PH_STEP_CYCLES(PHS)) u_blfs_top (.clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'h1),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .vcc_ok_i(vok), .vcc_start_i(vst),
    .res_upper_i(up), .res_lower_i(lo), .res_high_i(hi), .res_grounded_i(rgnd),
    .lamp_sink_current_i(sink), .lamp_grounded_i(lgnd), .lamp_ac_over_i(acov),
    .lamp_dc_over_i(dcov), .lamp_channel_enable_level_i(len),
    .high_side_supply_rise_i(hsr), .high_side_supply_hold_i(hsh), .node_settled_i(ns),
    .low_gate_req_i(lreq), .high_gate_req_i(hreq), .discontinuous_conduction_i(discontinuous_conduction),
    .pfc_off_time_i(poff), .src_sel_o(src), .filament_threshold_lower_o(thr),
    .low_gate_drive_o(lgd), .high_gate_drive_o(hgd), .aux_drive_o(aux),
    .power_down_o(pd), .start_permit_o(sp), .preheat_active_o(pha));
  blfs_front u_blfs_front (.clk_i(clk), .src_sel_i(src), .low_gate_i(lgd), .high_gate_i(hgd),
    .res_kohm_i(kohm), .ext_mv_i(ext), .res_upper_o(up), .res_lower_o(lo), .res_high_o(hi),
    .node_settled_o(ns));
  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int got, input int lo_b, input int hi_b);
    cmp_count++;
    if (got < lo_b || got > hi_b) begin
      error_cnt++;
      $display("mismatch at %0t: %0d cycles, outside %0d..%0d", $time, got, lo_b, hi_b);
    end
  endtask : chk_in
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    cyc <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      c++;
    end while (ack !== 1'h1 && c < 50);
    rd = rdat;
    chk_in(c, 1, 49);
    cyc <= 1'h0;
    we <= 1'h0;
    @(posedge clk);
  endtask : wb
  task automatic st(input logic [3:0] e);
    wb(1'h0, ADR_STATUS, 32'h0);
    chk(rd[15:12], e);
  endtask : st
  // 0 waits for power down, 1 for start permit, 2 for the high gate
  task automatic wt(input int s, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (c < 400 && (s == 0 ? pd : (s == 1 ? sp : hgd)) !== 1'h1);
  endtask : wt
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (10) @(posedge clk);
    chk({pd, lgd, hgd, sp, aux}, 32'h0);
    rst_n <= 1'h1;
    @(posedge clk);
    foreach (rows[i]) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].e);
    end
    vok <= 1'h1;
    hsr <= 1'h1;
    hsh <= 1'h1;
    sink <= 2'h3;
    repeat (8) @(posedge clk);
    chk(src, BLFS_SRC_NORMAL);
    sink <= 2'h0;
    repeat (8) @(posedge clk);
    chk(src, BLFS_SRC_HS_OPEN_HIGH);
    kohm <= 16'h03E8;
    repeat (8) @(posedge clk);
    chk({thr, src}, {1'h1, BLFS_SRC_HS_OPEN_LOW});
    sink <= 2'h3;
    repeat (8) @(posedge clk);
    chk({thr, src}, {1'h1, BLFS_SRC_REDUCED});
    vst <= 1'h1;
    repeat (8) @(posedge clk);
    st(4'h1);
    kohm <= 16'h0005;
    wt(1, n);
    chk_in(n, 2, 12);
    @(posedge clk);
    chk(pha, 1'h1);
    st(4'h2);
    repeat (12) @(posedge clk);
    chk(pha, 1'h0);
    lreq <= 1'h1;
    repeat (6) @(posedge clk);
    chk(lgd, 1'h1);
    lreq <= 1'h0;
    hreq <= 1'h1;
    wt(2, n);
    chk_in(n, int'(DT_MIN_CYC), int'(DT_MAX_CYC) + 4);
    hreq <= 1'h0;
    hsr <= 1'h0;
    repeat (4) @(posedge clk);
    wb(1'h0, ADR_STATUS, 32'h0);
    chk(rd[5], 1'h1);
    hsh <= 1'h0;
    repeat (4) @(posedge clk);
    wb(1'h0, ADR_STATUS, 32'h0);
    chk(rd[5], 1'h0);
    hsr <= 1'h1;
    hsh <= 1'h1;
    discontinuous_conduction <= 1'h1;
    poff <= 1'h1;
    repeat (2) @(posedge clk);
    chk(aux, 1'h1);
    discontinuous_conduction <= 1'h0;
    repeat (2) @(posedge clk);
    chk(aux, 1'h0);
    poff <= 1'h0;
    repeat (3) begin
      acov <= 2'h2;
      repeat (FILT - 3) @(posedge clk);
      acov <= 2'h0;
      repeat (3) @(posedge clk);
    end
    chk(pd, 1'h0);
    lreq <= 1'h1;
    ext <= 16'h0DAC;
    wt(0, n);
    chk_in(n, FILT + 1, FILT + 8);
    @(posedge clk);
    chk({lgd, hgd}, 32'h0);
    lreq <= 1'h0;
    ext <= 16'h0000;
    wt(1, n);
    // counting starts one edge after power down was seen
    chk_in(n, RETRY - 1, RETRY + 2);
    dcov <= 2'h1;
    wt(0, n);
    chk_in(n, DCF + 1, DCF + 8);
    dcov <= 2'h0;
    repeat (30) @(posedge clk);
    st(4'h8);
    // supply below start keeps the cleared sequence waiting in detect
    vst <= 1'h0;
    sink <= 2'h2;
    repeat (6) @(posedge clk);
    st(4'h1);
    // grounded inputs drop out of detection, channel a comes back in run
    lgnd <= 2'h1;
    rgnd <= 1'h1;
    repeat (6) @(posedge clk);
    chk(src, BLFS_SRC_OFF);
    wb(1'h0, ADR_STATUS, 32'h0);
    chk(rd[8:6], 3'h4);
    lgnd <= 2'h0;
    rgnd <= 1'h0;
    vst <= 1'h1;
    wt(1, n);
    len <= 2'h1;
    repeat (4) @(posedge clk);
    wb(1'h0, ADR_STATUS, 32'h0);
    chk(rd[15:7], {4'h2, 3'h0, 2'h3});
    acov <= 2'h1;
    wt(0, n);
    chk_in(n, FILT + 1, FILT + 8);
    acov <= 2'h0;
    wb(1'h0, ADR_FAULT, 32'h0);
    chk(rd, 32'h2);
    vok <= 1'h0;
    hreq <= 1'h1;
    repeat (8) @(posedge clk);
    chk(hgd, 1'h0);
    close_out();
  end
endmodule : test_ballast_lamp_fault_supervisor
`default_nettype wire
